// *** rtl/ame_cmd_exec.sv ***
// accumulator motion command executor with apb register access
//
// Overview of operation
// - Instruction 46 is the accumulator move; motor/bank picks axis 0 to 5 (stored point number for type 2), value is ignored.
// - The move type selects absolute (0), offset from actual position (1) or stored point (2).
// - The move copies the target into position parameter 0 of the addressed axis, or of axis 0 for a stored point (type 2).
// - The move does not block: status 100 is replied right after setup, new commands accepted.
// - Target arithmetic is 32 bits and wraps, so over-long distances run the short way.
// - Ramp settings stay in the axis parameters; only the target is written by a command.
// - A later rotate for the same axis overrides a positioning move in progress.
// - Instruction 50 is rotate left at accumulator speed; motor/bank picks axis 0 to 5.
// - Rotate left drives the axis towards a decrementing position counter.
// - Both rotates first select velocity mode, then write velocity parameter 2.
// - Instruction 51 is rotate right, same fields, incrementing the position counter.
// - Each rotate to axis 0 to 5 is answered with status 100.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ame_params.svh"

module ame_cmd_exec (
    input  wire logic            clk_in,
    input  wire logic            rst_b_in,
    input  wire logic            psel_in,
    input  wire logic            penable_in,
    input  wire logic            pwrite_in,
    input  wire logic [7:0]      paddr_in,
    input  wire logic [31:0]     pwdata_in,
    output logic [31:0]          prdata_out,
    output logic                 pready_out,
    output logic                 pslverr_out,
    input  wire logic [5:0][31:0] mc_actpos_in,
    input  wire logic [31:0]     stored_point_type_pos_in,
    output logic [7:0]           stored_point_type_idx_out,
    output logic                 mc_wr_out,
    output logic [2:0]           mc_axis_out,
    output logic [7:0]           mc_param_out,
    output logic [31:0]          mc_value_out,
    output logic                 mc_mode_wr_out,
    output logic                 mc_vel_mode_out,
    output logic                 mc_dir_out
);
    ame_pkg::ame_exec_state_t s_q;
    ame_pkg::ame_exec_state_t s_d;

    logic        apb_wr;
    logic        apb_rd_setup;
    logic        mapped;
    logic        byte_push;
    logic        rpl_clr;
    logic        resync;
    logic        rx_ok;
    logic        rx_bad;
    logic [7:0]  rx_addr;
    logic [7:0]  rx_instr;
    logic [7:0]  rx_type;
    logic [7:0]  rx_mb;
    logic        rpl_valid;
    logic [31:0] rpl_hdr;
    logic [31:0] rpl_val;
    logic [7:0]  rpl_ck;
    logic        is_rot;

    assign apb_wr       = psel_in & penable_in & pwrite_in;
    assign apb_rd_setup = psel_in & ~penable_in & ~pwrite_in;
    assign mapped       = (paddr_in == `AME_OFF_ACCU) || (paddr_in == `AME_OFF_FRAME)
                        || (paddr_in == `AME_OFF_STATUS) || (paddr_in == `AME_OFF_REPLY_HDR)
                        || (paddr_in == `AME_OFF_REPLY_VAL) || (paddr_in == `AME_OFF_REPLY_CK)
                        || (paddr_in == `AME_OFF_MOD_ADDR);
    // zero wait states; error only for an unmapped address
    assign pready_out   = 1'b1;
    assign pslverr_out  = psel_in & penable_in & ~mapped;
    // bytes written while a command runs are dropped, the host waits for the reply
    assign byte_push    = apb_wr && (paddr_in == `AME_OFF_FRAME) && (s_q.st == ame_pkg::ame_st_idle);
    assign rpl_clr      = apb_wr && (paddr_in == `AME_OFF_STATUS) && pwdata_in[`AME_STAT_RPL_BIT];
    assign resync       = apb_wr && (paddr_in == `AME_OFF_STATUS) && pwdata_in[`AME_STAT_SYNC_BIT];
    assign is_rot       = (s_q.instr == `AME_INSTR_ROT_L) || (s_q.instr == `AME_INSTR_ROT_R);

    ame_frame_rx u_rx (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .byte_valid_in (byte_push),
        .byte_in       (pwdata_in[7:0]),
        .resync_in     (resync),
        .frame_ok_out  (rx_ok),
        .frame_bad_out (rx_bad),
        .addr_out      (rx_addr),
        .instr_out     (rx_instr),
        .type_out      (rx_type),
        .mb_out        (rx_mb)
    );

    ame_reply_tx u_tx (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .load_in     (s_q.rpl_ld),
        .clear_in    (rpl_clr),
        .mod_addr_in (s_q.mod_addr),
        .status_in   (s_q.rpl_stat),
        .instr_in    (s_q.instr),
        .value_in    (s_q.accu),
        .valid_out   (rpl_valid),
        .hdr_out     (rpl_hdr),
        .val_out     (rpl_val),
        .ck_out      (rpl_ck)
    );

    always_comb begin
        s_d         = s_q;
        s_d.mc_wr   = 1'b0;
        s_d.mode_wr = 1'b0;
        s_d.rpl_ld  = 1'b0;
        if (apb_wr) begin
            case (paddr_in)
                `AME_OFF_ACCU: begin
                    s_d.accu = pwdata_in;
                end
                `AME_OFF_MOD_ADDR: begin
                    s_d.mod_addr = pwdata_in[7:0];
                end
                `AME_OFF_STATUS: begin
                    if (pwdata_in[`AME_STAT_CKERR_BIT]) begin
                        s_d.ckerr = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (apb_rd_setup) begin
            case (paddr_in)
                `AME_OFF_ACCU:      s_d.prdata = s_q.accu;
                `AME_OFF_STATUS:    s_d.prdata = {28'h0000000, 1'b0,
                                                  s_q.st != ame_pkg::ame_st_idle,
                                                  s_q.ckerr, rpl_valid};
                `AME_OFF_REPLY_HDR: s_d.prdata = rpl_hdr;
                `AME_OFF_REPLY_VAL: s_d.prdata = rpl_val;
                `AME_OFF_REPLY_CK:  s_d.prdata = {24'h000000, rpl_ck};
                `AME_OFF_MOD_ADDR:  s_d.prdata = {24'h000000, s_q.mod_addr};
                default:            s_d.prdata = 32'h00000000;
            endcase
        end
        // fsm after the bus writes so a hardware set wins over a software clear
        case (s_q.st)
            ame_pkg::ame_st_idle: begin
                if (rx_bad) begin
                    s_d.ckerr    = 1'b1;
                    s_d.instr    = rx_instr;
                    s_d.rpl_stat = `AME_ST_BAD_CKSUM;
                    s_d.st       = ame_pkg::ame_st_reply;
                end else if (rx_ok && (rx_addr == s_q.mod_addr)) begin
                    s_d.instr = rx_instr;
                    s_d.typ   = rx_type;
                    s_d.st    = ame_pkg::ame_st_decode;
                end
            end
            ame_pkg::ame_st_decode: begin
                s_d.st = ame_pkg::ame_st_reply;
                if (!(s_q.instr == `AME_INSTR_MOVE) && !is_rot) begin
                    s_d.rpl_stat = `AME_ST_BAD_CMD;
                end else if ((s_q.instr == `AME_INSTR_MOVE) && (s_q.typ > `AME_TYPE_POINT)) begin
                    s_d.rpl_stat = `AME_ST_BAD_TYPE;
                end else if ((s_q.instr == `AME_INSTR_MOVE) && (s_q.typ == `AME_TYPE_POINT)) begin
                    // stored point number is the motor/bank byte, applied to axis 0
                    s_d.stored_point_type_idx = rx_mb;
                    s_d.axis      = 3'h0;
                    s_d.st        = ame_pkg::ame_st_stored_point_type;
                end else if (rx_mb > `AME_AXIS_MAX) begin
                    s_d.rpl_stat = `AME_ST_BAD_VALUE;
                end else begin
                    s_d.axis = rx_mb[2:0];
                    s_d.st   = ame_pkg::ame_st_mode;
                    if ((s_q.instr == `AME_INSTR_MOVE) && (s_q.typ == `AME_TYPE_RELATIVE)) begin
                        s_d.tgt = s_q.accu + mc_actpos_in[rx_mb[2:0]];
                    end else begin
                        s_d.tgt = s_q.accu;
                    end
                end
            end
            ame_pkg::ame_st_stored_point_type: begin
                s_d.tgt = stored_point_type_pos_in;
                s_d.st  = ame_pkg::ame_st_mode;
            end
            ame_pkg::ame_st_mode: begin
                // a rotate switching to velocity mode cancels any move underway
                s_d.mode_wr  = 1'b1;
                s_d.vel_mode = is_rot;
                s_d.dir      = (s_q.instr == `AME_INSTR_ROT_R);
                s_d.st       = ame_pkg::ame_st_param;
            end
            ame_pkg::ame_st_param: begin
                // only the target is written; ramp limits stay as the axis holds them
                s_d.mc_wr    = 1'b1;
                s_d.mc_param = is_rot ? `AME_PARAM_TGT_VEL : `AME_PARAM_TGT_POS;
                s_d.mc_value = s_q.tgt;
                s_d.rpl_stat = `AME_ST_OK;
                s_d.st       = ame_pkg::ame_st_reply;
            end
            ame_pkg::ame_st_reply: begin
                s_d.rpl_ld = 1'b1;
                s_d.st     = ame_pkg::ame_st_idle;
            end
            default: begin
                s_d.st = ame_pkg::ame_st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q          <= '0;
            s_q.st       <= ame_pkg::ame_st_idle;
            s_q.accu     <= `AME_ACCU_RST;
            s_q.mod_addr <= `AME_MOD_ADDR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_out      = s_q.prdata;
    assign stored_point_type_idx_out   = s_q.stored_point_type_idx;
    assign mc_wr_out       = s_q.mc_wr;
    assign mc_axis_out     = s_q.axis;
    assign mc_param_out    = s_q.mc_param;
    assign mc_value_out    = s_q.mc_value;
    assign mc_mode_wr_out  = s_q.mode_wr;
    assign mc_vel_mode_out = s_q.vel_mode;
    assign mc_dir_out      = s_q.dir;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_move_decode: assert property (
        (s_q.st == ame_pkg::ame_st_idle) && rx_ok && (rx_addr == s_q.mod_addr)
        && (rx_instr == `AME_INSTR_MOVE) && (rx_type == `AME_TYPE_ABSOLUTE)
        && (rx_mb <= `AME_AXIS_MAX)
        |-> ##4 (mc_wr_out && (mc_axis_out == rx_mb[2:0])))
        else $error("move to axis not issued");

    a_absolute_target: assert property (
        (s_q.st == ame_pkg::ame_st_decode) && (s_d.st == ame_pkg::ame_st_mode)
        && (s_q.instr == `AME_INSTR_MOVE) && (s_q.typ == `AME_TYPE_ABSOLUTE)
        |=> (s_q.tgt == $past(s_q.accu)))
        else $error("absolute target differs from accumulator");

    a_move_param_zero: assert property (
        mc_wr_out && (s_q.instr == `AME_INSTR_MOVE)
        |-> (mc_param_out == `AME_PARAM_TGT_POS) && !mc_vel_mode_out)
        else $error("move wrote wrong parameter");

    a_reply_ok_after: assert property (
        mc_wr_out |=> s_q.rpl_ld ##1 (rpl_valid && (rpl_hdr[15:8] == `AME_ST_OK)))
        else $error("ok reply not produced after setup");

    a_busy_bounded: assert property (
        (s_q.st == ame_pkg::ame_st_decode) |-> ##[1:5] (s_q.st == ame_pkg::ame_st_idle))
        else $error("command did not finish in time");

    a_relative_wraps: assert property (
        (s_q.st == ame_pkg::ame_st_decode) && (s_d.st == ame_pkg::ame_st_mode)
        && (s_q.instr == `AME_INSTR_MOVE) && (s_q.typ == `AME_TYPE_RELATIVE)
        |=> (s_q.tgt == 32'($past(s_q.accu) + $past(mc_actpos_in[rx_mb[2:0]]))))
        else $error("relative target not 32-bit sum");

    a_only_target: assert property (
        mc_wr_out |-> (mc_param_out == `AME_PARAM_TGT_POS) || (mc_param_out == `AME_PARAM_TGT_VEL))
        else $error("command wrote a ramp parameter");

    a_vel_mode_first: assert property (
        mc_wr_out && (mc_param_out == `AME_PARAM_TGT_VEL)
        |-> $past(mc_mode_wr_out) && mc_vel_mode_out && (mc_value_out == s_q.tgt))
        else $error("velocity written without mode switch");

    a_left_dir: assert property (
        mc_mode_wr_out && (s_q.instr == `AME_INSTR_ROT_L) |-> mc_vel_mode_out && !mc_dir_out)
        else $error("rotate left has wrong direction");

    a_right_dir: assert property (
        mc_mode_wr_out && (s_q.instr == `AME_INSTR_ROT_R) |-> mc_vel_mode_out && mc_dir_out)
        else $error("rotate right has wrong direction");

    a_rot_reply: assert property (
        mc_wr_out && mc_vel_mode_out |=> s_q.rpl_ld && (s_q.rpl_stat == `AME_ST_OK))
        else $error("rotate not answered ok");

    a_bad_cksum: assert property (
        rx_bad && (s_q.st == ame_pkg::ame_st_idle)
        |=> s_q.ckerr ##1 (s_q.rpl_ld && !mc_wr_out && (s_q.rpl_stat == `AME_ST_BAD_CKSUM)))
        else $error("checksum error not flagged");

    c_move_abs: cover property (mc_wr_out && (mc_param_out == `AME_PARAM_TGT_POS));
    c_rot_left: cover property (mc_mode_wr_out && mc_vel_mode_out && !mc_dir_out);
    c_rot_right: cover property (mc_mode_wr_out && mc_vel_mode_out && mc_dir_out);
    c_cksum_err: cover property (rx_bad ##2 s_q.rpl_ld);

endmodule // ame_cmd_exec
`default_nettype wire

// *** common/ame_params.svh ***
// offsets, field values, reset values and status codes of the accumulator motion executor
`ifndef AME_PARAMS_SVH
`define AME_PARAMS_SVH

`define AME_OFF_ACCU        8'h00
`define AME_OFF_FRAME       8'h04
`define AME_OFF_STATUS      8'h08
`define AME_OFF_REPLY_HDR   8'h0C
`define AME_OFF_REPLY_VAL   8'h10
`define AME_OFF_REPLY_CK    8'h14
`define AME_OFF_MOD_ADDR    8'h18

`define AME_MOD_ADDR_RST    8'h01
`define AME_HOST_ADDR       8'h02
`define AME_ACCU_RST        32'h00000000

`define AME_INSTR_MOVE      8'h2E
`define AME_INSTR_ROT_L     8'h32
`define AME_INSTR_ROT_R     8'h33

`define AME_TYPE_ABSOLUTE   8'h00
`define AME_TYPE_RELATIVE   8'h01
`define AME_TYPE_POINT      8'h02
`define AME_AXIS_MAX        8'h05

`define AME_PARAM_TGT_POS   8'h00
`define AME_PARAM_TGT_VEL   8'h02

`define AME_ST_OK           8'h64
`define AME_ST_BAD_CKSUM    8'h01
`define AME_ST_BAD_CMD      8'h02
`define AME_ST_BAD_TYPE     8'h03
`define AME_ST_BAD_VALUE    8'h04

`define AME_LAST_BYTE       4'h8

`define AME_STAT_RPL_BIT    0
`define AME_STAT_CKERR_BIT  1
`define AME_STAT_BUSY_BIT   2
`define AME_STAT_SYNC_BIT   3

`endif

// *** common/ame_pkg.sv ***
// types of the accumulator motion executor
`default_nettype none
package ame_pkg;

    typedef enum logic [2:0] {
        ame_st_idle,
        ame_st_decode,
        ame_st_stored_point_type,
        ame_st_mode,
        ame_st_param,
        ame_st_reply
    } ame_state_t;

    typedef struct packed {
        logic [3:0]      cnt;
        logic [7:0]      sum;
        logic [7:0][7:0] byt;
        logic            ok;
        logic            bad;
    } ame_rx_state_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] hdr;
        logic [31:0] val;
        logic [7:0]  ck;
    } ame_tx_state_t;

    typedef struct packed {
        ame_state_t  st;
        logic [31:0] accu;
        logic [7:0]  mod_addr;
        logic        ckerr;
        logic [2:0]  axis;
        logic [7:0]  instr;
        logic [7:0]  typ;
        logic [31:0] tgt;
        logic [7:0]  stored_point_type_idx;
        logic        mc_wr;
        logic [7:0]  mc_param;
        logic [31:0] mc_value;
        logic        mode_wr;
        logic        vel_mode;
        logic        dir;
        logic        rpl_ld;
        logic [7:0]  rpl_stat;
        logic [31:0] prdata;
    } ame_exec_state_t;

endpackage
`default_nettype wire

// *** rtl/ame_frame_rx.sv ***
// command frame assembler with checksum check
`timescale 1ns/10ps
`default_nettype none
`include "ame_params.svh"

module ame_frame_rx (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       byte_valid_in,
    input  wire logic [7:0] byte_in,
    input  wire logic       resync_in,
    output logic            frame_ok_out,
    output logic            frame_bad_out,
    output logic [7:0]      addr_out,
    output logic [7:0]      instr_out,
    output logic [7:0]      type_out,
    output logic [7:0]      mb_out
);
    ame_pkg::ame_rx_state_t s_q;
    ame_pkg::ame_rx_state_t s_d;

    always_comb begin
        s_d     = s_q;
        s_d.ok  = 1'b0;
        s_d.bad = 1'b0;
        if (resync_in) begin
            s_d.cnt = 4'h0;
            s_d.sum = 8'h00;
        end else if (byte_valid_in) begin
            if (s_q.cnt == `AME_LAST_BYTE) begin
                // ninth byte is the checksum of the eight before it
                s_d.ok  = (byte_in == s_q.sum);
                s_d.bad = (byte_in != s_q.sum);
                s_d.cnt = 4'h0;
                s_d.sum = 8'h00;
            end else begin
                s_d.byt[s_q.cnt[2:0]] = byte_in;
                s_d.sum = s_q.sum + byte_in;
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign frame_ok_out  = s_q.ok;
    assign frame_bad_out = s_q.bad;
    assign addr_out      = s_q.byt[0];
    assign instr_out     = s_q.byt[1];
    assign type_out      = s_q.byt[2];
    assign mb_out        = s_q.byt[3];

endmodule // ame_frame_rx
`default_nettype wire

// *** rtl/ame_reply_tx.sv ***
// reply frame holder with checksum
`timescale 1ns/10ps
`default_nettype none
`include "ame_params.svh"

module ame_reply_tx (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        load_in,
    input  wire logic        clear_in,
    input  wire logic [7:0]  mod_addr_in,
    input  wire logic [7:0]  status_in,
    input  wire logic [7:0]  instr_in,
    input  wire logic [31:0] value_in,
    output logic             valid_out,
    output logic [31:0]      hdr_out,
    output logic [31:0]      val_out,
    output logic [7:0]       ck_out
);
    ame_pkg::ame_tx_state_t s_q;
    ame_pkg::ame_tx_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (clear_in) begin
            s_d.valid = 1'b0;
        end
        // load after clear so a new reply is never lost
        if (load_in) begin
            s_d.valid = 1'b1;
            s_d.hdr   = {`AME_HOST_ADDR, mod_addr_in, status_in, instr_in};
            s_d.val   = value_in;
            s_d.ck    = `AME_HOST_ADDR + mod_addr_in + status_in + instr_in
                      + value_in[31:24] + value_in[23:16] + value_in[15:8] + value_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign valid_out = s_q.valid;
    assign hdr_out   = s_q.hdr;
    assign val_out   = s_q.val;
    assign ck_out    = s_q.ck;

endmodule // ame_reply_tx
`default_nettype wire

// *** bench/ame_mc_model.sv ***
// behavioural motion controller seen from the executor: axis parameters and positions
`timescale 1ns/10ps
`default_nettype none

module ame_mc_model (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [7:0]       stored_point_type_idx_in,
    input  wire logic             mc_wr_in,
    input  wire logic [2:0]       mc_axis_in,
    input  wire logic [7:0]       mc_param_in,
    input  wire logic [31:0]      mc_value_in,
    input  wire logic             mc_mode_wr_in,
    input  wire logic             mc_vel_mode_in,
    input  wire logic             mc_dir_in,
    output logic [5:0][31:0]      actpos_out,
    output logic [31:0]           stored_point_type_pos_out,
    output logic                  order_err_out
);
    logic [31:0] tgt_pos [6];
    logic [31:0] tgt_vel [6];
    logic        velm    [6];
    logic        dirq    [6];

    // positions near the sign boundary so offsets can wrap
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            actpos_out[i] = 32'h7FFFFF00 + 32'(i);
        end
        stored_point_type_pos_out = {24'hC0FFEE, stored_point_type_idx_in};
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            order_err_out <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                velm[i] <= 1'b0;
                dirq[i] <= 1'b0;
            end
        end else begin
            if (mc_mode_wr_in) begin
                velm[mc_axis_in] <= mc_vel_mode_in;
                dirq[mc_axis_in] <= mc_dir_in;
            end
            if (mc_wr_in && mc_param_in == 8'h00) begin
                tgt_pos[mc_axis_in] <= mc_value_in;
            end
            if (mc_wr_in && mc_param_in == 8'h02) begin
                tgt_vel[mc_axis_in] <= mc_value_in;
                // velocity written before the mode switch is an ordering fault
                if (!velm[mc_axis_in]) begin
                    order_err_out <= 1'b1;
                end
            end
        end
    end
endmodule // ame_mc_model
`default_nettype wire

// *** bench/accu_motion_command_exec_tb.sv ***
// self-checking bench of the accumulator motion executor
`timescale 1ns/10ps
`default_nettype none

module accu_motion_command_exec_tb;
    typedef struct packed {
        logic [7:0]  ins;
        logic [7:0]  ty;
        logic [7:0]  mb;
        logic [31:0] accu;
        logic [7:0]  st;
        logic [2:0]  ax;
        logic [31:0] val;
    } ame_row_t;

    logic            clk_in = 1'b0;
    logic            rst_b_in = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h00000000;
    logic [31:0]     prdata, stored_point_type_pos, mc_value, x, h;
    logic            pready, pslverr, mc_wr, mode_wr, vel_mode, dir, order_err, last_err;
    logic [5:0][31:0] actpos;
    logic [7:0]      stored_point_type_idx, mc_param;
    logic [2:0]      mc_axis;
    int              failures = 0;
    int              num_checks = 0;

    ame_row_t rows [10] = '{
        '{8'h2E, 8'h00, 8'h03, 32'h12345678, 8'h64, 3'h3, 32'h12345678},
        '{8'h2E, 8'h01, 8'h05, 32'h80000100, 8'h64, 3'h5, 32'h00000005},
        '{8'h2E, 8'h02, 8'h07, 32'h00000000, 8'h64, 3'h0, 32'hC0FFEE07},
        '{8'h32, 8'h00, 8'h01, 32'h00000FA0, 8'h64, 3'h1, 32'h00000FA0},
        '{8'h33, 8'h07, 8'h02, 32'h00001F40, 8'h64, 3'h2, 32'h00001F40},
        '{8'h2E, 8'h00, 8'h04, 32'h00000040, 8'h64, 3'h4, 32'h00000040},
        '{8'h32, 8'h00, 8'h04, 32'h00000020, 8'h64, 3'h4, 32'h00000020},
        '{8'h2E, 8'h03, 8'h00, 32'h00000001, 8'h03, 3'h0, 32'h00000000},
        '{8'h32, 8'h00, 8'h06, 32'h00000001, 8'h04, 3'h0, 32'h00000000},
        '{8'h2D, 8'h00, 8'h00, 32'h00000001, 8'h02, 3'h0, 32'h00000000}
    };

    always #10 clk_in = ~clk_in;

    ame_cmd_exec i_ame_cmd_exec (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .mc_actpos_in(actpos),
        .stored_point_type_pos_in(stored_point_type_pos), .stored_point_type_idx_out(stored_point_type_idx), .mc_wr_out(mc_wr),
        .mc_axis_out(mc_axis), .mc_param_out(mc_param), .mc_value_out(mc_value),
        .mc_mode_wr_out(mode_wr), .mc_vel_mode_out(vel_mode), .mc_dir_out(dir));

    ame_mc_model i_ame_mc_model (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .stored_point_type_idx_in(stored_point_type_idx), .mc_wr_in(mc_wr),
        .mc_axis_in(mc_axis), .mc_param_in(mc_param), .mc_value_in(mc_value),
        .mc_mode_wr_in(mode_wr), .mc_vel_mode_in(vel_mode), .mc_dir_in(dir),
        .actpos_out(actpos), .stored_point_type_pos_out(stored_point_type_pos), .order_err_out(order_err));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // one transfer; waits on pready, samples data at that same edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic frame(input ame_row_t r, input logic bad, output logic [31:0] hd);
        logic [7:0]  b [9];
        logic [31:0] y;
        int          i;
        b = '{8'h01, r.ins, r.ty, r.mb, 8'h5A, 8'hA5, 8'h0F, 8'hF0, 8'h00};
        for (i = 0; i < 8; i++) b[8] = b[8] + b[i];
        b[8] = b[8] ^ {7'h00, bad};
        apb(1'b1, 8'h00, r.accu, y);
        for (i = 0; i < 9; i++) apb(1'b1, 8'h04, {24'h000000, b[i]}, y);
        y = 32'h00000000;
        for (i = 0; i < 20 && y[0] !== 1'b1; i++) apb(1'b0, 8'h08, 32'h00000000, y);
        chk("reply valid", {31'h0, y[0]}, 32'h1);
        apb(1'b0, 8'h0C, 32'h00000000, hd);
    endtask

    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        report_and_stop;
    end

    initial begin
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        apb(1'b0, 8'h18, 32'h00000000, x);
        chk("module addr reset", x, 32'h00000001);
        apb(1'b0, 8'h00, 32'h00000000, x);
        chk("accu reset", x, 32'h00000000);
        apb(1'b0, 8'h1C, 32'h00000000, x);
        chk("unmapped error", {31'h0, last_err}, 32'h1);
        chk("unmapped data", x, 32'h00000000);
        foreach (rows[k]) begin
            frame(rows[k], 1'b0, h);
            chk("reply header", {8'h00, h[31:8]},
                {8'h00, 16'h0201, rows[k].st});
            apb(1'b0, 8'h10, 32'h00000000, x);
            chk("reply value", x, rows[k].accu);
            apb(1'b0, 8'h14, 32'h00000000, x);
            // host 02h plus module 01h, then status, instruction and value bytes
            chk("reply sum", x, {24'h000000, 8'h03 + rows[k].st + rows[k].ins
                + rows[k].accu[31:24] + rows[k].accu[23:16] + rows[k].accu[15:8]
                + rows[k].accu[7:0]});
            apb(1'b1, 8'h08, 32'h00000001, x);
            if (rows[k].st == 8'h64 && rows[k].ins == 8'h2E) begin
                chk("target pos", i_ame_mc_model.tgt_pos[rows[k].ax],
                    rows[k].val);
                chk("pos mode", {31'h0, i_ame_mc_model.velm[rows[k].ax]}, 32'h0);
            end else if (rows[k].st == 8'h64) begin
                chk("target vel", i_ame_mc_model.tgt_vel[rows[k].ax],
                    rows[k].val);
                chk("vel mode", {31'h0, i_ame_mc_model.velm[rows[k].ax]}, 32'h1);
                chk("direction", {31'h0, i_ame_mc_model.dirq[rows[k].ax]},
                    {31'h0, rows[k].ins == 8'h33});
            end
        end
        frame(rows[0], 1'b1, h);
        chk("bad sum status", {24'h0, h[15:8]}, 32'h00000001);
        apb(1'b0, 8'h08, 32'h00000000, x);
        chk("sum error flag", {31'h0, x[1]}, 32'h1);
        apb(1'b1, 8'h08, 32'h00000003, x);
        apb(1'b0, 8'h08, 32'h00000000, x);
        chk("flags cleared", {30'h0, x[1:0]}, 32'h0);
        chk("mode before velocity", {31'h0, order_err}, 32'h0);
        // stray bytes, then a counter resync realigns the next frame
        apb(1'b1, 8'h04, 32'h00000011, x);
        apb(1'b1, 8'h04, 32'h00000022, x);
        apb(1'b1, 8'h08, 32'h00000008, x);
        frame(rows[3], 1'b0, h);
        chk("resync header", {8'h00, h[31:8]}, {8'h00, 16'h0201, rows[3].st});
        apb(1'b1, 8'h18, 32'h00000005, x);
        apb(1'b0, 8'h18, 32'h00000000, x);
        chk("module addr write", x, 32'h00000005);
        // reset in mid-run with a reply still pending
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        apb(1'b0, 8'h08, 32'h00000000, x);
        chk("status after reset", x, 32'h00000000);
        apb(1'b0, 8'h18, 32'h00000000, x);
        chk("module addr after reset", x, 32'h00000001);
        report_and_stop;
    end
endmodule // accu_motion_command_exec_tb
`default_nettype wire
